// >>> interval_timer_wakeup.sv
// interval timer with stop-mode release and start-up hold
//
// Behaviour
// - eight-bit counter runs freely, stops only while in stop mode
// - counter advances once per prescaler pulse
// - reset sets all prescaler select bits
// - wrap FF to 00 sets overflow flag
// - select code divides by two^(code+3)
// - clear bit write zeroes counter, counting resumes
// - clear bit self-returns to zero next cycle
// - shared address: read count, write control
// - stop leaves on reset or listed interrupts
// - only sources enabled before stop wake it
// - event-pin timer match can release stop
// - reset reinitialises registers; interrupt release keeps control, clears count
// - start-up interval holds internal operation after release
// - stop halts oscillator clocks and the counter
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module interval_timer_wakeup (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`DATA_W-1:0] reg_rdata,
	input wire logic main_osc_tick,
	input wire logic sub_osc_tick,
	input wire logic [1:0] system_clock_mode_select,
	input wire logic stop_request,
	input wire logic ext_irq,
	input wire logic watch_irq,
	input wire logic serial_irq,
	input wire logic keyscan_irq,
	input wire logic event_timer_irq,
	input wire logic event_count_mode,
	output logic stop_active,
	output logic startup_hold,
	output logic interval_overflow_flag,
	output logic irq
);

	// ******************************************************************
	// declarations
	// ******************************************************************

	prescale_if pre_link ();

	interval_timer_pkg::power_state_t state_q;
	interval_timer_pkg::power_state_t state_d;
	interval_timer_pkg::prescale_code_t sel_q;
	logic clr_q;
	logic [`CNT_W-1:0] count_q;
	logic [`CNT_W-1:0] count_d;
	logic [`ST_W-1:0] status_q;
	logic [`ST_W-1:0] status_d;
	logic [`ST_W-1:0] mask_q;
	logic [`SRC_W-1:0] wake_en_q;
	logic [`DATA_W-1:0] rdata_q;
	logic [`DATA_W-1:0] rdata_d;

	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;
	logic wr_wake_en;
	logic in_stop;
	logic in_startup;
	logic osc_tick;
	logic [`SRC_W-1:0] wake_src;
	logic wake;
	logic restart;
	logic overflow;
	logic [`ST_W-1:0] events;
	logic [`ST_W-1:0] clear_bits;

	// ******************************************************************
	// register bus decode
	// ******************************************************************

	assign wr_ctrl = reg_wr && (reg_addr == `ADDR_COUNT_CTRL);
	assign wr_status = reg_wr && (reg_addr == `ADDR_STATUS);
	assign wr_mask = reg_wr && (reg_addr == `ADDR_MASK);
	assign wr_wake_en = reg_wr && (reg_addr == `ADDR_WAKE_EN);

	// ******************************************************************
	// power state and wake sources
	// ******************************************************************

	assign in_stop = (state_q == interval_timer_pkg::st_stop);
	assign in_startup = (state_q == interval_timer_pkg::st_startup);

	// event-pin timer keeps counting with the oscillator stopped
	assign wake_src = {
		event_timer_irq && event_count_mode,
		keyscan_irq,
		serial_irq,
		watch_irq,
		ext_irq
	};
	// enables are frozen while stopped, so only prior settings count
	assign wake = in_stop && |(wake_src & wake_en_q);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			interval_timer_pkg::st_run: begin
				if (stop_request) begin
					state_d = interval_timer_pkg::st_stop;
				end
			end
			interval_timer_pkg::st_stop: begin
				if (wake) begin
					state_d = interval_timer_pkg::st_startup;
				end
			end
			interval_timer_pkg::st_startup: begin
				if (overflow) begin
					state_d = interval_timer_pkg::st_run;
				end
			end
			default: begin
				state_d = interval_timer_pkg::st_startup;
			end
		endcase
	end

	// ******************************************************************
	// prescaler and interval counter
	// ******************************************************************

	// oscillator ticks are gated off while stopped
	assign osc_tick = in_stop ? 1'b0 :
		(system_clock_mode_select[1] ? sub_osc_tick : main_osc_tick);
	assign restart = clr_q || wake;

	assign pre_link.tick_in = osc_tick;
	assign pre_link.clear = restart;
	assign pre_link.code = sel_q;

	interval_prescaler u_prescaler (
		.sys_clk(sys_clk),
		.rst(rst),
		.link(pre_link)
	);

	assign overflow = pre_link.pulse && (count_q == `COUNT_MAX);
	assign count_d = restart ? `COUNT_ZERO :
		(pre_link.pulse ? count_q + `CNT_W'(1) : count_q);

	// ******************************************************************
	// interrupt status
	// ******************************************************************

	assign events = {wake, overflow};
	assign clear_bits = wr_status ? reg_wdata[`ST_W-1:0] : '0;
	// a new event beats a simultaneous write-one clear
	assign status_d = (status_q & ~clear_bits) | events;

	// ******************************************************************
	// read data
	// ******************************************************************

	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				`ADDR_COUNT_CTRL: rdata_d = count_q;
				`ADDR_STATUS: rdata_d = {{(`DATA_W-`ST_W){1'b0}}, status_q};
				`ADDR_MASK: rdata_d = {{(`DATA_W-`ST_W){1'b0}}, mask_q};
				`ADDR_WAKE_EN: rdata_d = {{(`DATA_W-`SRC_W){1'b0}}, wake_en_q};
				default: rdata_d = '0;
			endcase
		end
	end

	// ******************************************************************
	// registers
	// ******************************************************************

	// reset reinitialises all control; interrupt release keeps it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= interval_timer_pkg::st_startup;
			sel_q <= `CTL_SEL_RESET;
			clr_q <= 1'b0;
			count_q <= `COUNT_ZERO;
			status_q <= '0;
			mask_q <= '0;
			wake_en_q <= '0;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			if (wr_ctrl) begin
				sel_q <= reg_wdata[`CTL_SEL_MSB:`CTL_SEL_LSB];
			end
			clr_q <= wr_ctrl && reg_wdata[`CTL_CLR_BIT];
			count_q <= count_d;
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= reg_wdata[`ST_W-1:0];
			end
			if (wr_wake_en && !in_stop) begin
				wake_en_q <= reg_wdata[`SRC_W-1:0];
			end
			rdata_q <= rdata_d;
		end
	end

	// ******************************************************************
	// outputs
	// ******************************************************************

	assign reg_rdata = rdata_q;
	assign stop_active = in_stop;
	assign startup_hold = in_startup;
	assign interval_overflow_flag = status_q[`ST_OVF_BIT];
	assign irq = |(status_q & mask_q);

endmodule : interval_timer_wakeup

`default_nettype wire

// >>> interval_timer_consts.svh
// offsets, field positions and reset values of the interval timer
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 8
`define CNT_W 8
`define PRE_W 10
`define SRC_W 5

// shared read/write address: read gives the count, write gives the control
`define ADDR_COUNT_CTRL 8'hF4
`define ADDR_STATUS 8'hF5
`define ADDR_MASK 8'hF6
`define ADDR_WAKE_EN 8'hF7

// control register fields
`define CTL_SEL_LSB 0
`define CTL_SEL_MSB 2
`define CTL_CLR_BIT 3
`define CTL_SEL_RESET 3'h7

// status and mask fields
`define ST_OVF_BIT 0
`define ST_WAKE_BIT 1
`define ST_W 2

// wake source enable fields
`define WK_EXT_BIT 0
`define WK_WATCH_BIT 1
`define WK_SERIAL_BIT 2
`define WK_KEYSCAN_BIT 3
`define WK_EVENT_BIT 4

`define PRE_BASE_SHIFT 4'h3
`define COUNT_MAX 8'hFF
`define COUNT_ZERO 8'h00

`endif

// >>> interval_timer_pkg.sv
// types shared by the interval timer modules
package interval_timer_pkg;

	typedef enum logic [2:0] {
		st_run = 3'b001,
		st_stop = 3'b010,
		st_startup = 3'b100
	} power_state_t;

	typedef logic [2:0] prescale_code_t;

endpackage : interval_timer_pkg

// >>> prescale_if.sv
// link between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none

interface prescale_if;
	logic tick_in;
	logic clear;
	interval_timer_pkg::prescale_code_t code;
	logic pulse;

	modport ctrl (output tick_in, output clear, output code, input pulse);
	modport pre (input tick_in, input clear, input code, output pulse);
endinterface : prescale_if

`default_nettype wire

// >>> interval_prescaler.sv
// power-of-two prescaler for the interval counter
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module interval_prescaler (
	input wire logic sys_clk,
	input wire logic rst,
	prescale_if.pre link
);

	logic [`PRE_W-1:0] div_q;
	logic [`PRE_W-1:0] div_d;
	logic [`PRE_W-1:0] sel_mask;

	// low (code + 3) bits set
	function automatic logic [`PRE_W-1:0] low_mask(input logic [2:0] code);
		logic [3:0] width;
		width = {1'b0, code} + `PRE_BASE_SHIFT;
		low_mask = (`PRE_W'(1) << width) - `PRE_W'(1);
	endfunction : low_mask

	assign sel_mask = low_mask(link.code);
	// one pulse every 2^(code+3) source ticks
	assign link.pulse = link.tick_in && !link.clear && ((div_q & sel_mask) == sel_mask);
	assign div_d = link.clear ? '0 : (link.tick_in ? div_q + `PRE_W'(1) : div_q);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

endmodule : interval_prescaler

`default_nettype wire

// >>> interval_timer_monitor.sv
// port assertions for the interval timer
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module interval_timer_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic main_osc_tick,
	input wire logic sub_osc_tick,
	input wire logic [1:0] system_clock_mode_select,
	input wire logic stop_request,
	input wire logic ext_irq,
	input wire logic watch_irq,
	input wire logic serial_irq,
	input wire logic keyscan_irq,
	input wire logic event_timer_irq,
	input wire logic event_count_mode,
	input wire logic stop_active,
	input wire logic startup_hold,
	input wire logic interval_overflow_flag,
	input wire logic irq
);
	// ****
	// checks
	// ****
	wire logic any_src = ext_irq | watch_irq | serial_irq | keyscan_irq | event_timer_irq;
	wire logic st_wr = reg_wr && reg_addr == `ADDR_STATUS;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence run_stop_s; stop_request && !stop_active && !startup_hold; endsequence
	sequence quiet_stop_s; stop_active && !any_src; endsequence
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata");
	stop_entry_a: assert property (run_stop_s |=> stop_active) else $error("no stop");
	stop_keep_a: assert property (quiet_stop_s |=> stop_active) else $error("woke");
	stop_exit_a: assert property (stop_active |=> stop_active || startup_hold) else $error("exit");
	hold_excl_a: assert property (startup_hold |-> !stop_active) else $error("hold");
	hold_end_a: assert property ($fell(startup_hold) |-> interval_overflow_flag) else $error("end");
	flag_keep_a: assert property (interval_overflow_flag && !st_wr |=> interval_overflow_flag)
		else $error("flag lost");
	stop_frozen_a: assert property (stop_active && $past(stop_active) |->
		!$rose(interval_overflow_flag)) else $error("counted in stop");
	event_gate_a: assert property (stop_active && !event_count_mode &&
		!(ext_irq | watch_irq | serial_irq | keyscan_irq) |=> stop_active) else $error("event woke");
endmodule : interval_timer_monitor

bind interval_timer_wakeup interval_timer_monitor mon (.sys_clk(sys_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick),
	.system_clock_mode_select(system_clock_mode_select), .stop_request(stop_request),
	.ext_irq(ext_irq), .watch_irq(watch_irq), .serial_irq(serial_irq), .keyscan_irq(keyscan_irq),
	.event_timer_irq(event_timer_irq), .event_count_mode(event_count_mode),
	.stop_active(stop_active), .startup_hold(startup_hold),
	.interval_overflow_flag(interval_overflow_flag), .irq(irq));

`default_nettype wire

// >>> tb.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic tm = 1'b0;
	logic ts = 1'b0;
	logic [1:0] mode = 2'h0;
	logic stp = 1'b0;
	logic [4:0] src = 5'h00;
	logic ecm = 1'b1;
	logic [7:0] rdat;
	logic sa, sh, fl, irq;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	always #12.5 sys_clk = ~sys_clk;
	interval_timer_wakeup dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(adr), .reg_wdata(wd),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .main_osc_tick(tm), .sub_osc_tick(ts),
		.system_clock_mode_select(mode), .stop_request(stp), .ext_irq(src[0]), .watch_irq(src[1]),
		.serial_irq(src[2]), .keyscan_irq(src[3]), .event_timer_irq(src[4]), .event_count_mode(ecm),
		.stop_active(sa), .startup_hold(sh), .interval_overflow_flag(fl), .irq(irq));
	// ****
	// tasks
	// ****
	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_s <= 1'b1;
		adr <= a;
		wd <= d;
		@(posedge sys_clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		rd_s <= 1'b1;
		adr <= a;
		@(posedge sys_clk);
		rd_s <= 1'b0;
		#1 chk("read", rdat, e);
	endtask : rd
	task automatic give(input int n, input logic s);
		@(posedge sys_clk);
		tm <= !s;
		ts <= s;
		repeat (n) @(posedge sys_clk);
		tm <= 1'b0;
		ts <= 1'b0;
	endtask : give
	task automatic stop_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			stop_test;
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h10, 8'h00);
		chk("hold", 8'(sh), 8'h01);
		give(1024, 1'b0);
		rd(`ADDR_COUNT_CTRL, 8'h01);
		for (int c = 0; c < 8; c++) begin
			wr(`ADDR_COUNT_CTRL, 8'h08 | 8'(c));
			give((8 << c) * 2, 1'b0);
			rd(`ADDR_COUNT_CTRL, 8'h02);
		end
		@(posedge sys_clk) mode <= 2'h2;
		wr(`ADDR_COUNT_CTRL, 8'h08);
		give(16, 1'b0);
		rd(`ADDR_COUNT_CTRL, 8'h00);
		@(posedge sys_clk) mode <= 2'h3;
		give(16, 1'b1);
		rd(`ADDR_COUNT_CTRL, 8'h02);
		@(posedge sys_clk) mode <= 2'h0;
		wr(`ADDR_COUNT_CTRL, 8'h08);
		give(2048, 1'b0);
		@(posedge sys_clk);
		#1 chk("ovf", {6'h00, fl, sh}, 8'h02);
		wr(`ADDR_MASK, 8'h01);
		#1 chk("irq", 8'(irq), 8'h01);
		wr(`ADDR_STATUS, 8'h01);
		#1 chk("clr", {6'h00, fl, irq}, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(`ADDR_WAKE_EN, 8'(1 << i));
			give(40, 1'b0);
			wr(`ADDR_COUNT_CTRL, 8'h00);
			@(posedge sys_clk) stp <= 1'b1;
			@(posedge sys_clk) stp <= 1'b0;
			wr(`ADDR_WAKE_EN, 8'h1F);
			give(16, 1'b0);
			rd(`ADDR_COUNT_CTRL, 8'h05);
			@(posedge sys_clk) begin
				src <= (i == 4) ? 5'h1F : ~(5'h01 << i);
				ecm <= (i != 4);
			end
			repeat (3) @(posedge sys_clk);
			#1 chk("stop", 8'(sa), 8'h01);
			@(posedge sys_clk) begin
				src <= 5'h01 << i;
				ecm <= 1'b1;
			end
			repeat (3) @(posedge sys_clk);
			#1 chk("wake", {6'h00, sa, sh}, 8'h01);
			@(posedge sys_clk) src <= 5'h00;
			give(2040, 1'b0);
			#1 chk("held", 8'(sh), 8'h01);
			give(8, 1'b0);
			@(posedge sys_clk);
			#1 chk("run", 8'(sh), 8'h00);
			rd(`ADDR_WAKE_EN, 8'(1 << i));
			rd(`ADDR_STATUS, 8'h03);
			wr(`ADDR_STATUS, 8'h03);
		end
		stop_test;
	end
endmodule : tb

`default_nettype wire
